// *** verilog/rtc_pkg.sv ***
// Shared constants, encodings and state types for the two-wire register port
package rtc_pkg;

	typedef logic [7:0] rtc_byte_type;
	typedef logic [1:0] rtc_op_type;

	// Fixed device address, 0b1101001
	localparam logic [6:0] DEV_ADDR = 7'h69;
	localparam logic       RW_WRITE = 1'h0;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT  = 4'h8;

	// Byte roles within one transfer
	localparam logic [1:0] PH_ADDR = 2'h0;
	localparam logic [1:0] PH_OFFS = 2'h1;
	localparam logic [1:0] PH_DATA = 2'h2;

	// Host command codes
	localparam rtc_op_type OP_START = 2'h0;
	localparam rtc_op_type OP_STOP  = 2'h1;
	localparam rtc_op_type OP_WRITE = 2'h2;
	localparam rtc_op_type OP_READ  = 2'h3;

	// Timing: one bit is four quarters, two low and two high
	localparam int CLK_NS     = 20;
	localparam int SCL_MAX_HZ = 400000;
	localparam int SCL_LOW_NS = 1300;
	localparam int QTR_NS     = SCL_LOW_NS / 2;
	localparam int QTR_CYC    = (QTR_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [5:0] QTR_LAST = 6'(QTR_CYC - 1);

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_RECV = 5'b00010,
		S_RACK = 5'b00100,
		S_SEND = 5'b01000,
		S_MACK = 5'b10000
	} rtc_slv_state_type;

	typedef enum logic [3:0] {
		M_IDLE  = 4'b0001,
		M_START = 4'b0010,
		M_BIT   = 4'b0100,
		M_STOP  = 4'b1000
	} rtc_mst_state_type;

endpackage

// *** verilog/rtc_i2c_if.sv ***
// Two-wire bus between host and device, open-drain levels resolved here
`timescale 1ns/1ns
interface rtc_i2c_if;
	logic scl_o;
	logic scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic scl;
	logic sda;

	// Pull-ups keep a line high unless someone drives it low
	assign scl = ~(scl_oe & ~scl_o);
	assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

	modport master (
		output scl_o,
		output scl_oe,
		output m_sda_o,
		output m_sda_oe,
		input  scl,
		input  sda
	);

	modport slave (
		output s_sda_o,
		output s_sda_oe,
		input  scl,
		input  sda
	);
endinterface

// *** verilog/rtc_slave.sv ***
// Device end: two-wire slave reaching a byte-wide register file
`timescale 1ns/1ns

module rtc_slave (
	input  wire logic                clk,
	input  wire logic                rst,
	rtc_i2c_if.slave                 bus,
	output logic [7:0]               reg_addr,
	output rtc_pkg::rtc_byte_type    reg_wdata,
	output logic                     reg_wr,
	output logic                     reg_rd,
	input  wire rtc_pkg::rtc_byte_type reg_rdata,
	output logic                     selected
);
	import rtc_pkg::*;

	logic [1:0]        scl_sync_ff;
	logic [1:0]        sda_sync_ff;
	logic              scl_prev_ff;
	logic              sda_prev_ff;
	rtc_slv_state_type state_ff;
	rtc_slv_state_type nxt_state;
	logic [3:0]        cnt_ff;
	logic [3:0]        nxt_cnt;
	rtc_byte_type      shift_ff;
	rtc_byte_type      nxt_shift;
	logic [1:0]        phase_ff;
	logic [1:0]        nxt_phase;
	logic              rw_ff;
	logic              nxt_rw;
	logic [7:0]        ptr_ff;
	logic [7:0]        nxt_ptr;
	logic              sda_oe_ff;
	logic              nxt_sda_oe;
	logic              wr_ff;
	logic              nxt_wr;
	logic              rd_ff;
	logic              nxt_rd;
	rtc_byte_type      wdata_ff;
	rtc_byte_type      nxt_wdata;
	logic              mack_ff;
	logic              nxt_mack;
	logic              sel_ff;

	wire scl_now    = scl_sync_ff[1];
	wire sda_now    = sda_sync_ff[1];
	wire scl_steady = scl_now & scl_prev_ff;
	wire cond_start = scl_steady & sda_prev_ff & ~sda_now;
	wire cond_stop  = scl_steady & ~sda_prev_ff & sda_now;
	wire scl_rise   = scl_now & ~scl_prev_ff;
	wire scl_fall   = ~scl_now & scl_prev_ff;
	wire byte_done  = scl_fall && (cnt_ff == ACK_BIT);
	wire addr_hit   = (shift_ff[7:1] == DEV_ADDR);
	wire send_last  = (cnt_ff == LAST_BIT);
	wire ptr_step   = wr_ff | rd_ff;

	assign bus.s_sda_o  = 1'b0;
	assign bus.s_sda_oe = sda_oe_ff;
	assign reg_addr     = ptr_ff;
	assign reg_wdata    = wdata_ff;
	assign reg_wr       = wr_ff;
	assign reg_rd       = rd_ff;
	assign selected     = sel_ff;

	// Two stages per line, then one more stage for edge finding
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end else begin
			scl_sync_ff <= {scl_sync_ff[0], bus.scl};
			sda_sync_ff <= {sda_sync_ff[0], bus.sda};
			scl_prev_ff <= scl_now;
			sda_prev_ff <= sda_now;
		end
	end

	always_comb begin
		nxt_state  = state_ff;
		nxt_cnt    = cnt_ff;
		nxt_shift  = shift_ff;
		nxt_phase  = phase_ff;
		nxt_rw     = rw_ff;
		nxt_sda_oe = sda_oe_ff;
		nxt_wdata  = wdata_ff;
		nxt_mack   = mack_ff;
		nxt_wr     = 1'b0;
		nxt_rd     = 1'b0;
		// Strobe cycle shows the old pointer, then it moves on
		nxt_ptr    = ptr_step ? ptr_ff + 8'h01 : ptr_ff;
		if (rd_ff) begin
			nxt_shift = reg_rdata;
		end
		if (cond_stop) begin
			nxt_state  = S_IDLE;
			nxt_sda_oe = 1'b0;
		end else if (cond_start) begin
			nxt_state  = S_RECV;
			nxt_cnt    = 4'h0;
			nxt_phase  = PH_ADDR;
			nxt_sda_oe = 1'b0;
		end else begin
			unique case (state_ff)
			S_IDLE: begin
				nxt_sda_oe = 1'b0;
			end
			S_RECV: begin
				if (scl_rise) begin
					nxt_shift = {shift_ff[6:0], sda_now};
					nxt_cnt   = cnt_ff + 4'h1;
				end else if (byte_done) begin
					nxt_cnt = 4'h0;
					if (phase_ff == PH_ADDR) begin
						if (addr_hit) begin
							nxt_rw     = shift_ff[0];
							nxt_phase  = (shift_ff[0] == RW_WRITE) ?
								PH_OFFS : PH_DATA;
							nxt_sda_oe = 1'b1;
							nxt_state  = S_RACK;
						end else begin
							nxt_state = S_IDLE;
						end
					end else if (phase_ff == PH_OFFS) begin
						nxt_ptr    = shift_ff;
						nxt_phase  = PH_DATA;
						nxt_sda_oe = 1'b1;
						nxt_state  = S_RACK;
					end else begin
						nxt_wdata  = shift_ff;
						nxt_wr     = 1'b1;
						nxt_sda_oe = 1'b1;
						nxt_state  = S_RACK;
					end
				end
			end
			S_RACK: begin
				// Low is held from one falling edge to the next
				if (scl_rise && rw_ff) begin
					nxt_rd = 1'b1;
				end else if (scl_fall) begin
					nxt_cnt = 4'h0;
					if (rw_ff) begin
						nxt_sda_oe = ~shift_ff[7];
						nxt_state  = S_SEND;
					end else begin
						nxt_sda_oe = 1'b0;
						nxt_state  = S_RECV;
					end
				end
			end
			S_SEND: begin
				if (scl_fall) begin
					if (send_last) begin
						nxt_sda_oe = 1'b0;
						nxt_state  = S_MACK;
					end else begin
						nxt_shift  = {shift_ff[6:0], 1'b0};
						nxt_sda_oe = ~shift_ff[6];
						nxt_cnt    = cnt_ff + 4'h1;
					end
				end
			end
			S_MACK: begin
				if (scl_rise) begin
					nxt_mack = ~sda_now;
					nxt_rd   = ~sda_now;
				end else if (scl_fall) begin
					nxt_cnt = 4'h0;
					if (mack_ff) begin
						nxt_sda_oe = ~shift_ff[7];
						nxt_state  = S_SEND;
					end else begin
						nxt_sda_oe = 1'b0;
						nxt_state  = S_IDLE;
					end
				end
			end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff  <= S_IDLE;
			cnt_ff    <= 4'h0;
			shift_ff  <= 8'h00;
			phase_ff  <= PH_ADDR;
			rw_ff     <= 1'b0;
			sda_oe_ff <= 1'b0;
			wdata_ff  <= 8'h00;
			mack_ff   <= 1'b0;
			wr_ff     <= 1'b0;
			rd_ff     <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			cnt_ff    <= nxt_cnt;
			shift_ff  <= nxt_shift;
			phase_ff  <= nxt_phase;
			rw_ff     <= nxt_rw;
			sda_oe_ff <= nxt_sda_oe;
			wdata_ff  <= nxt_wdata;
			mack_ff   <= nxt_mack;
			wr_ff     <= nxt_wr;
			rd_ff     <= nxt_rd;
		end
	end

	// Pointer survives STOP so a later read can reuse it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ptr_ff <= 8'h00;
			sel_ff <= 1'b0;
		end else begin
			ptr_ff <= nxt_ptr;
			sel_ff <= (nxt_state != S_IDLE) && (nxt_phase != PH_ADDR);
		end
	end

endmodule // rtc_slave

// *** verilog/rtc_master.sv ***
// Host end: two-wire master issuing START, STOP and byte commands
`timescale 1ns/1ns
module rtc_master (
	input  wire logic                  clk,
	input  wire logic                  rst,
	rtc_i2c_if.master                  bus,
	input  wire logic                  cmd_go,
	input  wire rtc_pkg::rtc_op_type   cmd_op,
	input  wire rtc_pkg::rtc_byte_type cmd_wdata,
	input  wire logic                  cmd_nak,
	output logic                       busy,
	output logic                       done,
	output logic                       got_ack,
	output rtc_pkg::rtc_byte_type      rdata
);
	import rtc_pkg::*;

	logic [1:0]        sda_sync_ff;
	rtc_mst_state_type state_ff;
	logic [5:0]        div_ff;
	logic [1:0]        q_ff;
	logic [3:0]        bit_ff;
	rtc_byte_type      tx_ff;
	rtc_byte_type      rx_ff;
	logic              rd_op_ff;
	logic              nak_ff;
	logic              scl_low_ff;
	logic              sda_low_ff;
	logic              busy_ff;
	logic              done_ff;
	logic              ack_ff;
	rtc_byte_type      rdata_ff;
	logic              nxt_scl_low;
	logic              nxt_sda_low;

	wire sda_now  = sda_sync_ff[1];
	wire tick     = (div_ff == QTR_LAST);
	wire step_end = tick && (q_ff == 2'h3);
	wire in_ack   = (bit_ff == ACK_BIT);
	wire take     = cmd_go && !busy_ff;
	wire bit_low  = in_ack ? (rd_op_ff & ~nak_ff) : (~rd_op_ff & ~tx_ff[7]);

	assign bus.scl_o    = 1'b0;
	assign bus.m_sda_o  = 1'b0;
	assign bus.scl_oe   = scl_low_ff;
	assign bus.m_sda_oe = sda_low_ff;
	assign busy         = busy_ff;
	assign done         = done_ff;
	assign got_ack      = ack_ff;
	assign rdata        = rdata_ff;

	// Line levels per quarter; data bits move SDA in the second low quarter, START and STOP also move it while SCL is high
	always_comb begin
		nxt_scl_low = scl_low_ff;
		nxt_sda_low = sda_low_ff;
		unique case (state_ff)
		M_IDLE: ;
		M_START: begin
			nxt_scl_low = (q_ff == 2'h0) || (q_ff == 2'h3);
			nxt_sda_low = q_ff[1];
		end
		M_BIT: begin
			nxt_scl_low = ~q_ff[1];
			if (q_ff == 2'h1) begin
				nxt_sda_low = bit_low;
			end
		end
		M_STOP: begin
			nxt_scl_low = ~q_ff[1];
			if (q_ff != 2'h0) begin
				nxt_sda_low = (q_ff != 2'h3);
			end
		end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sda_sync_ff <= 2'h3;
			scl_low_ff  <= 1'b0;
			sda_low_ff  <= 1'b0;
			done_ff     <= 1'b0;
		end else begin
			sda_sync_ff <= {sda_sync_ff[0], bus.sda};
			scl_low_ff  <= nxt_scl_low;
			sda_low_ff  <= nxt_sda_low;
			done_ff     <= step_end && (state_ff != M_BIT || in_ack);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= M_IDLE;
			div_ff   <= 6'h00;
			q_ff     <= 2'h0;
			bit_ff   <= 4'h0;
			tx_ff    <= 8'h00;
			rx_ff    <= 8'h00;
			rd_op_ff <= 1'b0;
			nak_ff   <= 1'b0;
			busy_ff  <= 1'b0;
			ack_ff   <= 1'b0;
			rdata_ff <= 8'h00;
		end else if (take) begin
			busy_ff  <= 1'b1;
			div_ff   <= 6'h00;
			q_ff     <= 2'h0;
			bit_ff   <= 4'h0;
			tx_ff    <= cmd_wdata;
			rd_op_ff <= (cmd_op == OP_READ);
			nak_ff   <= cmd_nak;
			if (cmd_op == OP_START) begin
				state_ff <= M_START;
			end else if (cmd_op == OP_STOP) begin
				state_ff <= M_STOP;
			end else begin
				state_ff <= M_BIT;
			end
		end else if (busy_ff) begin
			div_ff <= tick ? 6'h00 : div_ff + 6'h01;
			if (tick) begin
				q_ff <= q_ff + 2'h1;
			end
			if (step_end && state_ff == M_BIT && !in_ack) begin
				rx_ff  <= {rx_ff[6:0], sda_now};
				tx_ff  <= {tx_ff[6:0], 1'b1};
				bit_ff <= bit_ff + 4'h1;
			end else if (step_end) begin
				if (state_ff == M_BIT) begin
					ack_ff   <= ~sda_now;
					rdata_ff <= rx_ff;
				end
				state_ff <= M_IDLE;
				busy_ff  <= 1'b0;
			end
		end
	end

endmodule // rtc_master

// *** bench/rtc_link_monitor.sv ***
// Concurrent checks on the two-wire link between host and device
`timescale 1ns/1ns
module rtc_link_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic s_sda_oe
);
	import rtc_pkg::*;
	logic       scl_q_ff, sda_q_ff, first_ff, sel_ff, rw_ff, nak_ff, idle_ff;
	logic [3:0] bitc_ff;
	logic [7:0] sh_ff;
	wire        start_w = scl_q_ff & scl & sda_q_ff & ~sda;
	wire        stop_w  = scl_q_ff & scl & ~sda_q_ff & sda;
	wire        rise_w  = ~scl_q_ff & scl;
	wire        slot_w  = bitc_ff == 4'h8;
	wire        match_w = sh_ff[7:1] == DEV_ADDR;
	wire        rd_w    = sel_ff & rw_ff & ~first_ff;
	wire        due_w   = slot_w & (first_ff ? match_w : sel_ff & ~rw_ff);

	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	// Bit and byte tracking restarts at every START
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{scl_q_ff, sda_q_ff, idle_ff} <= 3'h7;
			{first_ff, sel_ff, rw_ff, nak_ff} <= 4'h0;
			bitc_ff <= 4'h0;
			sh_ff <= 8'h00;
		end else begin
			scl_q_ff <= scl;
			sda_q_ff <= sda;
			if (start_w) begin
				{first_ff, sel_ff, rw_ff, nak_ff, idle_ff} <= 5'h10;
				bitc_ff <= 4'h0;
			end else if (stop_w) begin
				idle_ff <= 1'b1;
			end else if (rise_w & slot_w) begin
				bitc_ff <= 4'h0;
				first_ff <= 1'b0;
				if (first_ff)
					{sel_ff, rw_ff} <= {match_w, sh_ff[0]};
				if (rd_w & sda)
					nak_ff <= 1'b1;
			end else if (rise_w) begin
				bitc_ff <= bitc_ff + 4'h1;
				sh_ff <= {sh_ff[6:0], sda};
			end
		end
	end

	addr_ack_a: assert property (
		rise_w && slot_w && first_ff |-> s_sda_oe == match_w)
		else $error("address acknowledge wrong");
	ack_timing_a: assert property (
		$fell(scl) && due_w |-> ##[1:8] s_sda_oe)
		else $error("acknowledge not driven");
	ack_hold_a: assert property (
		$rose(scl) && s_sda_oe |-> s_sda_oe [*8])
		else $error("low not held in high phase");
	sda_change_a: assert property (
		$changed(s_sda_oe) |-> !scl)
		else $error("data changed while clock high");
	nak_release_a: assert property (
		nak_ff |-> !s_sda_oe)
		else $error("data driven after NAK");
	idle_quiet_a: assert property (
		idle_ff || (!first_ff && !sel_ff) |-> !s_sda_oe)
		else $error("data driven while not addressed");
	host_slot_a: assert property (
		rise_w && slot_w && rd_w |-> !s_sda_oe)
		else $error("host acknowledge slot driven");
	host_bits_a: assert property (
		rise_w && !slot_w && !rd_w |-> !s_sda_oe)
		else $error("host data bit driven");

	cover property (rise_w && slot_w && !first_ff && sel_ff && !rw_ff);
	cover property (rise_w && slot_w && first_ff && !match_w);
	cover property (nak_ff && stop_w);
endmodule // rtc_link_monitor

// *** bench/tb.sv ***
// Bench joining host and device ends over the two-wire link
`timescale 1ns/1ns
module tb;
	import rtc_pkg::*;
	localparam rtc_byte_type AW = {DEV_ADDR, RW_WRITE};
	localparam rtc_byte_type AR = {DEV_ADDR, ~RW_WRITE};
	logic         clk, rst, cmd_go, cmd_nak, busy, done, got_ack;
	logic         reg_wr, reg_rd, selected;
	rtc_op_type   cmd_op;
	rtc_byte_type cmd_wdata, rdata, reg_wdata, reg_rdata;
	logic [7:0]   reg_addr;
	logic [7:0]   regs [256];
	int           failures, total_checks, cycles, wrcount, rdcount;

	rtc_i2c_if bus_if ();
	rtc_master u_rtc_master (.clk(clk), .rst(rst), .bus(bus_if),
		.cmd_go(cmd_go), .cmd_op(cmd_op), .cmd_wdata(cmd_wdata),
		.cmd_nak(cmd_nak), .busy(busy), .done(done), .got_ack(got_ack),
		.rdata(rdata));
	rtc_slave u_rtc_slave (.clk(clk), .rst(rst), .bus(bus_if),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .selected(selected));
	rtc_link_monitor u_rtc_link_monitor (.clk(clk), .rst(rst),
		.scl(bus_if.scl), .sda(bus_if.sda), .s_sda_oe(bus_if.s_sda_oe));

	// Register file answers reads combinationally from the pointer
	assign reg_rdata = regs[reg_addr];
	always @(posedge clk) begin
		if (reg_wr === 1'b1) begin
			regs[reg_addr] <= reg_wdata;
			wrcount <= wrcount + 1;
		end
		if (reg_rd === 1'b1) begin
			rdcount <= rdcount + 1;
		end
	end

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic results();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			failures++;
			results();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chkb(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask

	// One host command, waiting for its completion pulse
	task automatic cmd(input rtc_op_type op, input rtc_byte_type wd,
		input logic nk);
		int n;
		n = 0;
		@(posedge clk);
		cmd_op <= op;
		cmd_wdata <= wd;
		cmd_nak <= nk;
		cmd_go <= 1'b1;
		@(posedge clk);
		cmd_go <= 1'b0;
		@(negedge clk);
		while (done !== 1'b1 && n < 1300) begin
			@(negedge clk);
			n++;
		end
		if (n >= 1300)
			failures++;
		chkb(busy, 1'b0);
	endtask

	task automatic wb(input rtc_byte_type b, input logic ack);
		cmd(OP_WRITE, b, 1'b0);
		chkb(got_ack, ack);
	endtask

	task automatic rb(input logic nk, input rtc_byte_type exp);
		cmd(OP_READ, 8'h00, nk);
		chk(rdata, exp);
		chkb(got_ack, ~nk);
	endtask

	initial begin
		rst = 1'b1;
		cmd_go = 1'b0;
		cmd_nak = 1'b0;
		cmd_op = OP_START;
		cmd_wdata = 8'h00;
		failures = 0;
		total_checks = 0;
		cycles = 0;
		wrcount = 0;
		rdcount = 0;
		foreach (regs[i])
			regs[i] = 8'h00;
		regs[8'h01] = 8'h5A;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);

		cmd(OP_START, 8'h00, 1'b0);
		wb(AW, 1'b1);
		chkb(selected, 1'b1);
		wb(8'hFE, 1'b1);
		wb(8'hA5, 1'b1);
		wb(8'h3C, 1'b1);
		wb(8'h96, 1'b1);
		cmd(OP_STOP, 8'h00, 1'b0);
		chk(regs[8'hFE], 8'hA5);
		chk(regs[8'hFF], 8'h3C);
		chk(regs[8'h00], 8'h96);
		chk(reg_addr, 8'h01);
		$display("test burst_write done");

		cmd(OP_START, 8'h00, 1'b0);
		wb(AW, 1'b1);
		wb(8'hFF, 1'b1);
		cmd(OP_START, 8'h00, 1'b0);
		wb(AR, 1'b1);
		rb(1'b0, 8'h3C);
		rb(1'b1, 8'h96);
		cmd(OP_STOP, 8'h00, 1'b0);
		chk(8'(wrcount), 8'h03);
		chk(8'(rdcount), 8'h02);
		$display("test restart_read done");

		cmd(OP_START, 8'h00, 1'b0);
		wb(AR, 1'b1);
		rb(1'b1, 8'h5A);
		cmd(OP_STOP, 8'h00, 1'b0);
		chk(8'(rdcount), 8'h03);
		$display("test pointer_kept done");

		for (int k = 0; k < 2; k++) begin
			cmd(OP_START, 8'h00, 1'b0);
			wb(k == 0 ? 8'hD0 : 8'h52, 1'b0);
			wb(8'h00, 1'b0);
			chkb(selected, 1'b0);
		end
		cmd(OP_START, 8'h00, 1'b0);
		wb(AW, 1'b1);
		wb(8'h10, 1'b1);
		wb(8'h77, 1'b1);
		cmd(OP_STOP, 8'h00, 1'b0);
		chk(regs[8'h10], 8'h77);
		chk(8'(wrcount), 8'h04);
		$display("test wrong_address done");
		results();
	end
endmodule // tb
